// *** rtl/ccss_regs.sv ***
// Purpose: APB register bank for clock ratio, sidetone and DC servo control
// Assumes: single clock sys_clk, APB requests from the same clock domain
// Notes: one wait state on every transfer; irq status clears on read
`timescale 1ns/1ps
`include "ccss_params.svh"
module ccss_regs
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output ccss_pkg::ccss_ctl_t ctl
);

	////////////////////////////////////////////////////////////////////////
	// state of the whole bank
	typedef struct packed
	{
		logic [3:0] ratio;
		logic mono;
		logic [3:0] r_gain;
		logic [1:0] r_src;
		logic [3:0] l_gain;
		logic [1:0] l_src;
		logic [3:0] en;
		logic [6:0] steps;
		logic [1:0] bias_rsv;
		logic [2:0] bias;
		logic [3:0] done;
		ccss_pkg::ccss_path_t [3:0] path;
		logic [5:0] irq_sts;
		logic [5:0] irq_msk;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic irq;
		ccss_pkg::ccss_ctl_t ctl;
	} ccss_state_t;

	ccss_state_t s_q;
	ccss_state_t s_d;

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	// ratio code to master clock over sample rate
	function automatic logic [12:0] ccss_ratio(input logic [3:0] code);
		case (code)
			4'h0: ccss_ratio = 13'h0040;
			4'h1: ccss_ratio = 13'h0080;
			4'h2: ccss_ratio = 13'h00c0;
			4'h3: ccss_ratio = 13'h0100;
			4'h4: ccss_ratio = 13'h0180;
			4'h5: ccss_ratio = 13'h0200;
			4'h6: ccss_ratio = 13'h0300;
			4'h7: ccss_ratio = 13'h0400;
			4'h9: ccss_ratio = 13'h0600;
			4'ha: ccss_ratio = 13'h0c00;
			4'hb: ccss_ratio = 13'h1800;
			default: ccss_ratio = 13'h0000; // reserved codes
		endcase
	endfunction

	// sidetone gain code to attenuation in dB
	function automatic logic [5:0] ccss_atten(input logic [3:0] code);
		if (code[3:2] == 2'b11)
		begin
			ccss_atten = 6'h00;
		end
		else
		begin
			ccss_atten = 6'(6'h24 - 6'(code) * 6'h03);
		end
	endfunction

	// sidetone source code to {from right adc, from left adc}
	function automatic logic [1:0] ccss_src(input logic [1:0] code);
		case (code)
			2'b01: ccss_src = 2'b01;
			2'b10: ccss_src = 2'b10;
			default: ccss_src = 2'b00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic [6:0] idx;
	logic acc;
	logic wr;
	logic rd_done;
	logic mapped;
	logic [3:0] su_req;
	logic [3:0] se_req;
	logic [6:0] steps_eff;
	logic [5:0] sts_unread;

	assign idx = paddr[8:2];
	// status bits that the answer in flight did not report; only those survive a read clear
	assign sts_unread = s_q.irq_sts & ~s_q.rdata[5:0];
	// access phase before the answer; the answer edge is when rdy is high
	assign acc = psel & penable & ~s_q.rdy;
	assign wr = psel & penable & s_q.rdy & pwrite & ~s_q.err;
	assign rd_done = psel & penable & s_q.rdy & ~pwrite;

	// write-one triggers, one cycle wide
	assign su_req[0] = wr & (idx == `CCSS_IDX_SRV_IN) & pwdata[`CCSS_L_SU_BIT];
	assign su_req[1] = wr & (idx == `CCSS_IDX_SRV_IN) & pwdata[`CCSS_R_SU_BIT];
	assign su_req[2] = wr & (idx == `CCSS_IDX_SRV_HP) & pwdata[`CCSS_L_SU_BIT];
	assign su_req[3] = wr & (idx == `CCSS_IDX_SRV_HP) & pwdata[`CCSS_R_SU_BIT];
	assign se_req[1:0] = 2'b00;
	assign se_req[2] = wr & (idx == `CCSS_IDX_SRV_HP) & pwdata[`CCSS_L_SE_BIT];
	assign se_req[3] = wr & (idx == `CCSS_IDX_SRV_HP) & pwdata[`CCSS_R_SE_BIT];

	// reserved low counts run as the minimum series
	assign steps_eff = (s_q.steps < `CCSS_STEPS_MIN) ? `CCSS_STEPS_MIN : s_q.steps;

	always_comb
	begin
		case (idx)
			`CCSS_IDX_CLOCK, `CCSS_IDX_MIX_R, `CCSS_IDX_MIX_L,
			`CCSS_IDX_SRV_IN, `CCSS_IDX_SRV_HP, `CCSS_IDX_STEPS,
			`CCSS_IDX_DONE, `CCSS_IDX_BIAS, `CCSS_IDX_IRQ_STS,
			`CCSS_IDX_IRQ_MSK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		logic [5:0] ev;
		logic [15:0] rv;
		ev = 6'h00;
		rv = 16'h0000;
		s_d = s_q;
		s_d.ctl.servo_update = 4'h0;

		// one wait state, then the answer for one cycle
		s_d.rdy = acc;
		s_d.err = acc & ~mapped;

		// register writes at the answer edge
		if (wr)
		begin
			case (idx)
				`CCSS_IDX_CLOCK: s_d.ratio = pwdata[`CCSS_RATIO_LSB +: 4];
				`CCSS_IDX_MIX_R:
				begin
					s_d.mono = pwdata[`CCSS_MONO_BIT];
					s_d.r_gain = pwdata[`CCSS_GAIN_LSB +: 4];
					s_d.r_src = pwdata[`CCSS_SRC_LSB +: 2];
				end
				`CCSS_IDX_MIX_L:
				begin
					s_d.l_gain = pwdata[`CCSS_GAIN_LSB +: 4];
					s_d.l_src = pwdata[`CCSS_SRC_LSB +: 2];
				end
				`CCSS_IDX_SRV_IN:
				begin
					s_d.en[0] = pwdata[`CCSS_L_EN_BIT];
					s_d.en[1] = pwdata[`CCSS_R_EN_BIT];
				end
				`CCSS_IDX_SRV_HP:
				begin
					s_d.en[2] = pwdata[`CCSS_L_EN_BIT];
					s_d.en[3] = pwdata[`CCSS_R_EN_BIT];
				end
				`CCSS_IDX_STEPS: s_d.steps = pwdata[`CCSS_STEPS_LSB +: 7];
				`CCSS_IDX_BIAS:
				begin
					s_d.bias = pwdata[2:0];
					s_d.bias_rsv = pwdata[4:3];
				end
				`CCSS_IDX_IRQ_MSK: s_d.irq_msk = pwdata[5:0];
				default: s_d.bias = s_d.bias;
			endcase
		end

		// servo engines, one per path
		for (int i = 0; i < 4; i++)
		begin
			if (su_req[i])
			begin
				s_d.done[i] = 1'b0;
			end
			case (s_q.path[i].phase)
				ccss_pkg::CCSS_IDLE:
				begin
					if (su_req[i])
					begin
						s_d.path[i].phase = ccss_pkg::CCSS_STARTUP;
						s_d.path[i].cnt = 10'(`CCSS_STARTUP_CYC - 1);
					end
					else if (se_req[i])
					begin
						s_d.path[i].phase = ccss_pkg::CCSS_SERIES;
						s_d.path[i].cnt = 10'(`CCSS_UPDATE_CYC - 1);
						s_d.path[i].left = 7'(steps_eff - 7'h01);
					end
				end
				ccss_pkg::CCSS_STARTUP:
				begin
					if (su_req[i])
					begin
						s_d.path[i].cnt = 10'(`CCSS_STARTUP_CYC - 1);
					end
					else if (s_q.path[i].cnt == 10'h000)
					begin
						s_d.path[i].phase = ccss_pkg::CCSS_IDLE;
						s_d.done[i] = 1'b1;
						ev[i] = 1'b1;
					end
					else
					begin
						s_d.path[i].cnt = 10'(s_q.path[i].cnt - 10'h001);
					end
				end
				ccss_pkg::CCSS_SERIES:
				begin
					if (su_req[i])
					begin
						s_d.path[i].phase = ccss_pkg::CCSS_STARTUP;
						s_d.path[i].cnt = 10'(`CCSS_STARTUP_CYC - 1);
					end
					else if (s_q.path[i].cnt == 10'h000)
					begin
						s_d.ctl.servo_update[i] = 1'b1;
						s_d.path[i].cnt = 10'(`CCSS_UPDATE_CYC - 1);
						if (s_q.path[i].left == 7'h00)
						begin
							s_d.path[i].phase = ccss_pkg::CCSS_IDLE;
							ev[i + 2] = 1'b1;
						end
						else
						begin
							s_d.path[i].left = 7'(s_q.path[i].left - 7'h01);
						end
					end
					else
					begin
						s_d.path[i].cnt = 10'(s_q.path[i].cnt - 10'h001);
					end
				end
				default: s_d.path[i].phase = ccss_pkg::CCSS_IDLE;
			endcase
		end

		// sticky events; a new event wins over the read clear
		// the read clears only what it returned, so an event of the wait cycle is kept
		if (rd_done & (idx == `CCSS_IDX_IRQ_STS))
		begin
			s_d.irq_sts = sts_unread | ev;
		end
		else
		begin
			s_d.irq_sts = s_q.irq_sts | ev;
		end
		s_d.irq = |(s_d.irq_sts & s_d.irq_msk);

		// read data, captured in the wait cycle
		case (idx)
			`CCSS_IDX_CLOCK: rv = {11'h000, s_q.ratio, 1'b0};
			`CCSS_IDX_MIX_R: rv = {6'h00, s_q.mono, 1'b0, s_q.r_gain, s_q.r_src, 2'b00};
			`CCSS_IDX_MIX_L: rv = {8'h00, s_q.l_gain, s_q.l_src, 2'b00};
			`CCSS_IDX_SRV_IN: rv = {8'h00, s_q.en[0], 3'h0, s_q.en[1], 3'h0};
			`CCSS_IDX_SRV_HP: rv = {8'h00, s_q.en[2], 3'h0, s_q.en[3], 3'h0};
			`CCSS_IDX_STEPS: rv = {2'b00, s_q.steps, 7'h00};
			`CCSS_IDX_DONE: rv = {5'h00, s_q.done[0], s_q.done[1], s_q.done[2], s_q.done[3], 7'h00};
			`CCSS_IDX_BIAS: rv = {11'h000, s_q.bias_rsv, s_q.bias};
			`CCSS_IDX_IRQ_STS: rv = {10'h000, s_q.irq_sts};
			`CCSS_IDX_IRQ_MSK: rv = {10'h000, s_q.irq_msk};
			default: rv = 16'h0000;
		endcase
		s_d.rdata = acc ? {16'h0000, rv} : 32'h0000_0000;

		// decoded settings toward the datapath
		s_d.ctl.ratio_val = ccss_ratio(s_d.ratio);
		s_d.ctl.dac_mono_mix_sel = s_d.mono;
		s_d.ctl.mono_atten_6db = s_d.mono;
		s_d.ctl.left_sidetone_atten_db = ccss_atten(s_d.l_gain);
		s_d.ctl.right_sidetone_atten_db = ccss_atten(s_d.r_gain);
		{s_d.ctl.left_dac_from_right_adc, s_d.ctl.left_dac_from_left_adc} = ccss_src(s_d.l_src);
		{s_d.ctl.right_dac_from_right_adc, s_d.ctl.right_dac_from_left_adc} = ccss_src(s_d.r_src);
		s_d.ctl.servo_en = s_d.en;
		s_d.ctl.phone_gain_bias_boost = s_d.bias;
		for (int j = 0; j < 4; j++)
		begin
			s_d.ctl.startup_active[j] = (s_d.path[j].phase == ccss_pkg::CCSS_STARTUP);
			s_d.ctl.series_active[j] = (s_d.path[j].phase == ccss_pkg::CCSS_SERIES);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.ratio <= `CCSS_RATIO_RST;
			s_q.steps <= `CCSS_STEPS_RST;
			s_q.bias <= `CCSS_BIAS_RST;
			s_q.bias_rsv <= `CCSS_BIAS_RSV_RST;
			s_q.path <= {4{ccss_pkg::ccss_path_t'({ccss_pkg::CCSS_IDLE, 10'h000, 7'h00})}};
			s_q.ctl.ratio_val <= `CCSS_RATIO_VAL_RST;
			s_q.ctl.left_sidetone_atten_db <= `CCSS_ATTEN_RST;
			s_q.ctl.right_sidetone_atten_db <= `CCSS_ATTEN_RST;
			s_q.ctl.phone_gain_bias_boost <= `CCSS_BIAS_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign irq = s_q.irq;
	assign ctl = s_q.ctl;

	////////////////////////////////////////////////////////////////////////
	// checks
	ratio_decode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s_q.ratio == 4'hb) |-> (ctl.ratio_val == 13'h1800))
		else $error("ratio code 1011 not decoded as 6144");

	mono_atten_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		ctl.mono_atten_6db == ctl.dac_mono_mix_sel)
		else $error("mono attenuation does not follow mono mix");

	gain_top_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s_q.l_gain == 4'h0) |-> (ctl.left_sidetone_atten_db == 6'h24))
		else $error("sidetone code 0000 is not 36 dB down");

	src_none_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(s_q.r_src == 2'b11) |-> !(ctl.right_dac_from_left_adc | ctl.right_dac_from_right_adc))
		else $error("sidetone source 11 adds a signal");

	enable_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(wr && idx == `CCSS_IDX_SRV_IN) |=> (ctl.servo_en[0] == $past(pwdata[7])))
		else $error("input servo enable not taken from bit 7");

	startup_run_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		su_req[2] |=> (ctl.startup_active[2] && !s_q.done[2])[*8])
		else $error("phone start-up did not run after trigger");

	series_run_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(se_req[3] && !su_req[3] && s_q.path[3].phase == ccss_pkg::CCSS_IDLE) |=> ctl.series_active[3][*8])
		else $error("series did not start after trigger");

	done_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(ctl.startup_active[0]) && !$past(su_req[0]) |-> s_q.done[0] && s_q.irq_sts[0])
		else $error("start-up end without done flag");

	irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		irq == |(s_q.irq_sts & s_q.irq_msk))
		else $error("interrupt does not match masked status");

	sts_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!(rd_done && idx == `CCSS_IDX_IRQ_STS) |=> ((s_q.irq_sts & $past(s_q.irq_sts)) == $past(s_q.irq_sts)))
		else $error("status bit cleared without a read");

	sts_unread_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rd_done && idx == `CCSS_IDX_IRQ_STS) |=> ((s_q.irq_sts & $past(sts_unread)) == $past(sts_unread)))
		else $error("unreported status bit lost by the read clear");

	trig_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		su_req[1] |=> !s_q.done[1])
		else $error("done flag not cleared by new start-up");

endmodule

// *** rtl/ccss_params.svh ***
// Purpose: constants of the codec clock, sidetone and servo register bank
// Assumes: 100 MHz sys_clk, APB with 32-bit data, word index = paddr[8:2]
// Notes: offsets are word indices, byte address is four times the index
`ifndef CCSS_PARAMS_SVH
`define CCSS_PARAMS_SVH
// register word indices
`define CCSS_IDX_CLOCK 7'h38
`define CCSS_IDX_MIX_R 7'h39
`define CCSS_IDX_MIX_L 7'h3a
`define CCSS_IDX_SRV_IN 7'h3c
`define CCSS_IDX_SRV_HP 7'h3d
`define CCSS_IDX_STEPS 7'h40
`define CCSS_IDX_DONE 7'h42
`define CCSS_IDX_BIAS 7'h44
`define CCSS_IDX_IRQ_STS 7'h50
`define CCSS_IDX_IRQ_MSK 7'h51
// field positions
`define CCSS_RATIO_LSB 1
`define CCSS_MONO_BIT 9
`define CCSS_GAIN_LSB 4
`define CCSS_SRC_LSB 2
`define CCSS_L_EN_BIT 7
`define CCSS_L_SU_BIT 6
`define CCSS_L_SE_BIT 4
`define CCSS_R_EN_BIT 3
`define CCSS_R_SU_BIT 2
`define CCSS_R_SE_BIT 0
`define CCSS_STEPS_LSB 7
`define CCSS_DONE_LSB 7
// reset values and minimum step count
`define CCSS_RATIO_RST 4'h3
`define CCSS_STEPS_RST 7'h10
`define CCSS_STEPS_MIN 7'h10
`define CCSS_BIAS_RST 3'h3
`define CCSS_BIAS_RSV_RST 2'h3
`define CCSS_RATIO_VAL_RST 13'h0100
`define CCSS_ATTEN_RST 6'h24
// timing
`define CCSS_CLK_MHZ 100
`define CCSS_STARTUP_US 10
`define CCSS_UPDATE_NS 160
`define CCSS_STARTUP_CYC (`CCSS_STARTUP_US * `CCSS_CLK_MHZ)
`define CCSS_UPDATE_CYC ((`CCSS_UPDATE_NS * `CCSS_CLK_MHZ) / 1000)
`endif

// *** rtl/ccss_pkg.sv ***
// Purpose: types of the codec clock, sidetone and servo register bank
// Assumes: constants come from ccss_params.svh
// Notes: path order is left input, right input, left phone, right phone
package ccss_pkg;
	typedef enum logic [2:0]
	{
		CCSS_IDLE = 3'b001,
		CCSS_STARTUP = 3'b010,
		CCSS_SERIES = 3'b100
	} ccss_phase_t;

	// one servo engine
	typedef struct packed
	{
		ccss_phase_t phase;
		logic [9:0] cnt;
		logic [6:0] left;
	} ccss_path_t;

	// decoded settings driven to the audio datapath
	typedef struct packed
	{
		logic [12:0] ratio_val;
		logic dac_mono_mix_sel;
		logic mono_atten_6db;
		logic [5:0] left_sidetone_atten_db;
		logic [5:0] right_sidetone_atten_db;
		logic left_dac_from_left_adc;
		logic left_dac_from_right_adc;
		logic right_dac_from_left_adc;
		logic right_dac_from_right_adc;
		logic [3:0] servo_en;
		logic [3:0] startup_active;
		logic [3:0] series_active;
		logic [3:0] servo_update;
		logic [2:0] phone_gain_bias_boost;
	} ccss_ctl_t;
endpackage

// *** test/test_codec_clock_sidetone_servo_regs.sv ***
// Purpose: self-checking bench of the clock ratio, sidetone and servo register bank
// Assumes: bench is the APB master; the servo runs 1000 cycles at start-up, 16 per update
// Notes: tests run in order and share register state
`timescale 1ns/1ps
`include "ccss_params.svh"
module test_codec_clock_sidetone_servo_regs;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	ccss_pkg::ccss_ctl_t ctl;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] rdat;
	logic rerr;
	int ratio_tab [16] = '{64, 128, 192, 256, 384, 512, 768, 1024, 0, 1536, 3072, 6144, 0, 0, 0, 0};

	ccss_regs ccss_regs_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ctl(ctl));

	// 100 MHz clock
	always
	begin
		#5 sys_clk = ~sys_clk;
	end

	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task give_verdict();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one APB transfer: setup, access until pready, then one idle edge
	task apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {3'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk("pready", {31'h0, pready}, 32'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task wr(input logic [6:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task rd_chk(input logic [6:0] idx, input logic [31:0] exp, input string nm);
		apb(1'b0, idx, 32'h0);
		chk(nm, rdat, exp);
	endtask

	task wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 1500)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk("irq raised", {31'h0, irq}, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		chk("ratio_val", 32'(ctl.ratio_val), 32'd256);
		rd_chk(`CCSS_IDX_CLOCK, 32'h6, "clock reg");
		rd_chk(`CCSS_IDX_STEPS, 32'h800, "steps reg");
		rd_chk(`CCSS_IDX_BIAS, 32'h1b, "bias reg");
		rd_chk(`CCSS_IDX_DONE, 32'h0, "done reg");
		chk("bias", 32'(ctl.phone_gain_bias_boost), 32'h3);
		$display("test reset done");
	endtask

	task t_ratio();
		for (int c = 0; c < 16; c++)
		begin
			// reserved ratio codes are never programmed
			if (ratio_tab[c] == 0)
			begin
				continue;
			end
			wr(`CCSS_IDX_CLOCK, 32'(c << 1));
			rd_chk(`CCSS_IDX_CLOCK, 32'(c << 1), "clock reg");
			chk("ratio_val", 32'(ctl.ratio_val), 32'(ratio_tab[c]));
		end
		wr(`CCSS_IDX_CLOCK, 32'ha);
		$display("test ratio done");
	endtask

	task t_mix();
		for (int c = 0; c < 16; c++)
		begin
			logic [3:0] g;
			int e;
			g = 4'(c);
			e = (c >= 12) ? 0 : 36 - 3 * c;
			wr(`CCSS_IDX_MIX_R, 32'({g[0], 1'b0, g, g[1:0], 2'b00}));
			wr(`CCSS_IDX_MIX_L, 32'({g, g[1:0], 2'b00}));
			rd_chk(`CCSS_IDX_MIX_R, 32'({g[0], 1'b0, g, g[1:0], 2'b00}), "mix right reg");
			rd_chk(`CCSS_IDX_MIX_L, 32'({g, g[1:0], 2'b00}), "mix left reg");
			chk("left atten", 32'(ctl.left_sidetone_atten_db), 32'(e));
			chk("right atten", 32'(ctl.right_sidetone_atten_db), 32'(e));
			chk("mono", 32'({ctl.dac_mono_mix_sel, ctl.mono_atten_6db}), 32'({g[0], g[0]}));
			chk("src", 32'({ctl.left_dac_from_left_adc, ctl.left_dac_from_right_adc, ctl.right_dac_from_left_adc,
				ctl.right_dac_from_right_adc}), 32'({g[1:0] == 2'b01, g[1:0] == 2'b10, g[1:0] == 2'b01, g[1:0] == 2'b10}));
		end
		wr(`CCSS_IDX_MIX_R, 32'h0);
		$display("test mix done");
	endtask

	task t_input();
		int n;
		n = 0;
		wr(`CCSS_IDX_IRQ_MSK, 32'h3f);
		wr(`CCSS_IDX_SRV_IN, 32'hcc);
		rd_chk(`CCSS_IDX_SRV_IN, 32'h88, "input servo reg");
		rd_chk(`CCSS_IDX_DONE, 32'h0, "done while busy");
		chk("servo_en", 32'(ctl.servo_en[1:0]), 32'h3);
		while (ctl.startup_active[0] === 1'b1 && n < 1100)
		begin
			@(posedge sys_clk);
			n++;
		end
		chk("startup length", 32'(n >= 980 && n <= 1000), 32'h1);
		wait_irq();
		rd_chk(`CCSS_IDX_DONE, 32'h600, "done set");
		rd_chk(`CCSS_IDX_IRQ_STS, 32'h3, "irq status");
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rd_chk(`CCSS_IDX_IRQ_STS, 32'h0, "status cleared");
		wr(`CCSS_IDX_IRQ_MSK, 32'h0);
		wr(`CCSS_IDX_SRV_IN, 32'h40);
		rd_chk(`CCSS_IDX_DONE, 32'h200, "done cleared");
		repeat (1100) @(posedge sys_clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd_chk(`CCSS_IDX_IRQ_STS, 32'h1, "masked status");
		rd_chk(`CCSS_IDX_DONE, 32'h600, "done again");
		$display("test input servo done");
	endtask

	task t_phone();
		int n;
		n = 0;
		wr(`CCSS_IDX_STEPS, 32'h880);
		rd_chk(`CCSS_IDX_STEPS, 32'h880, "steps reg");
		wr(`CCSS_IDX_IRQ_MSK, 32'h3f);
		wr(`CCSS_IDX_SRV_HP, 32'h99);
		// count left updates over the whole series of 17
		repeat (340)
		begin
			@(posedge sys_clk);
			if (ctl.servo_update[2] === 1'b1)
				n++;
		end
		chk("update count", 32'(n), 32'd17);
		chk("series idle", 32'(ctl.series_active[3:2]), 32'h0);
		rd_chk(`CCSS_IDX_SRV_HP, 32'h88, "phone servo reg");
		rd_chk(`CCSS_IDX_IRQ_STS, 32'h30, "series status");
		wr(`CCSS_IDX_SRV_HP, 32'h44);
		chk("phone en", 32'(ctl.servo_en[3:2]), 32'h0);
		wait_irq();
		rd_chk(`CCSS_IDX_DONE, 32'h780, "phone done");
		rd_chk(`CCSS_IDX_IRQ_STS, 32'hc, "startup status");
		$display("test phone servo done");
	endtask

	task t_access();
		apb(1'b0, 7'h00, 32'h0);
		chk("unmapped err", {31'h0, rerr}, 32'h1);
		chk("unmapped data", rdat, 32'h0);
		apb(1'b1, `CCSS_IDX_DONE, 32'hffff);
		chk("done write err", {31'h0, rerr}, 32'h0);
		rd_chk(`CCSS_IDX_DONE, 32'h780, "done read only");
		wr(`CCSS_IDX_BIAS, 32'h18);
		rd_chk(`CCSS_IDX_BIAS, 32'h18, "bias reg");
		chk("bias", 32'(ctl.phone_gain_bias_boost), 32'h0);
		$display("test access done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_ratio();
		t_mix();
		t_input();
		t_phone();
		t_access();
		give_verdict();
	end
endmodule
